// *** testbench/fst_chk.sv ***
// Checker on the register port and frame-start pin that join the two ends.
`timescale 1ns/1ps
module fst_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic frame_start_pin_n,
    input wire logic dev_irq
);
    // One clock domain, so clocking and reset muting are declared once.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic rd_hi_q;

    // Marks the cycle in which read data of the control register stands.
    always_ff @(posedge clk_sys) begin
        rd_hi_q <= !rst && reg_rd && reg_addr == 8'h0f;
    end

    sequence s_low7; !frame_start_pin_n [*7]; endsequence
    sequence s_ctrl_wr; reg_wr && reg_addr == 8'h0f; endsequence
    sequence s_guard_off; reg_wr && reg_addr == 8'h10 && !reg_wdata[0]; endsequence

    property p_pulse; $fell(frame_start_pin_n) |=> s_low7 ##1 frame_start_pin_n; endproperty
    property p_dis; rd_hi_q && reg_rdata[3] |-> frame_start_pin_n; endproperty
    property p_guard;
        reg_wr && reg_addr == 8'h10 && reg_wdata[0] |=> s_ctrl_wr ##1 s_guard_off;
    endproperty
    property p_react; $fell(frame_start_pin_n) |-> ##[1:40] (reg_rd && reg_addr == 8'h0f); endproperty
    property p_irq; $rose(dev_irq) && !frame_start_pin_n |=> !dev_irq; endproperty
    property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    property p_excl; !(reg_wr && reg_rd); endproperty
    property p_rst; $fell(rst) |-> frame_start_pin_n && !dev_irq; endproperty

    a_pulse: assert property (p_pulse) else $error("pin pulse not eight cycles");
    a_dis: assert property (p_dis) else $error("pin low while disabled");
    a_guard: assert property (p_guard) else $error("guarded write out of order");
    a_react: assert property (p_react) else $error("frame start not serviced");
    a_irq: assert property (p_irq) else $error("interrupt outlived flag");
    a_rdz: assert property (p_rdz) else $error("read data outside its cycle");
    a_excl: assert property (p_excl) else $error("both strobes high");
    a_rst: assert property (p_rst) else $error("pin or interrupt wrong after reset");
endmodule

// *** testbench/tb_frame_start_tracker_endpoint_index.sv ***
// Testbench joining the device end and the controller end across the interface.
`timescale 1ns/1ps
module tb_frame_start_tracker_endpoint_index;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sof_rx_valid = 1'b0;
    logic [10:0] sof_rx_number = 11'h000;
    logic irq_channel_en = 1'b0;
    logic [23:0] ep_rdata = 24'h332211;
    logic [3:0] cmd_addr = 4'h0;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [7:0] cmd_rdata;
    logic irq;
    logic [2:0] ep_index;
    logic ep_rd;
    logic [1:0] ep_reg;
    logic ce = 1'b1;
    int err_total = 0;
    int n_tests = 0;
    int pin_low = 0;
    int rd_cnt = 0;
    int p0;

    fst_if fif ();

    fst_device #(.FRAME_CYCLES(200)) fst_device_inst (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(fif), .sof_rx_valid(sof_rx_valid),
        .sof_rx_number(sof_rx_number), .irq_channel_en(irq_channel_en), .ep_rdata(ep_rdata),
        .ep_index(ep_index), .ep_wr(), .ep_rd(ep_rd), .ep_reg(ep_reg), .ep_wdata()
    );
    fst_fw_ctrl fst_fw_ctrl_inst (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .bus(fif), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .irq(irq)
    );
    fst_chk fst_chk_inst (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(fif.reg_addr), .reg_wdata(fif.reg_wdata),
        .reg_wr(fif.reg_wr), .reg_rd(fif.reg_rd), .reg_rdata(fif.reg_rdata),
        .frame_start_pin_n(fif.frame_start_pin_n), .dev_irq(fif.dev_irq)
    );

    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;

    // Counts low pin cycles and receive port reads, so pulse widths are measured on the wire.
    always @(posedge clk_sys) begin
        if (fif.frame_start_pin_n === 1'b0) pin_low <= pin_low + 1;
        if (ep_rd === 1'b1) rd_cnt <= rd_cnt + 1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk_sys);
        cmd_wr <= 1'b0;
    endtask

    // The answer stands only in the cycle after the strobe, so it is taken there.
    task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string nm);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk_sys);
        cmd_rd <= 1'b0;
        #1;
        chk(nm, e, cmd_rdata & m);
    endtask

    task automatic sof(input logic [10:0] n);
        @(posedge clk_sys);
        sof_rx_valid <= 1'b1;
        sof_rx_number <= n;
        @(posedge clk_sys);
        sof_rx_valid <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly one thousand cycles the sequence needs.
    initial begin
        tick(20000);
        err_total++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        tick(5);
        rst <= 1'b0;
        tick(2);
        rchk(4'h3, 8'hff, 8'h00, "fnlo_reset");
        rchk(4'h4, 8'hff, 8'h00, "fnhi_reset");
        p0 = pin_low;
        sof(11'h5a3);
        tick(40);
        chk("pin_low_cycles", 8'h08, 8'(pin_low - p0));
        rchk(4'h3, 8'hff, 8'ha3, "fnlo");
        rchk(4'h4, 8'hef, 8'h85, "fnhi");
        rchk(4'h5, 8'h01, 8'h01, "start_seen");
        // A second SOF one frame later locks the timer.
        tick(150);
        sof(11'h5a4);
        tick(40);
        rchk(4'h4, 8'hff, 8'h95, "fnhi_locked");
        wr(4'h6, 8'h07);
        // Missing SOF: artificial start drops valid and lock, keeps the number.
        tick(240);
        rchk(4'h4, 8'hff, 8'h05, "fnhi_artificial");
        rchk(4'h3, 8'hff, 8'ha4, "fnlo_kept");
        rchk(4'h5, 8'h01, 8'h01, "artificial_seen");
        // Interrupt only with flag, enable and channel enable together.
        wr(4'h7, 8'h04);
        wr(4'h0, 8'h01);
        tick(20);
        wr(4'h6, 8'h07);
        sof(11'h123);
        tick(30);
        rchk(4'h5, 8'h04, 8'h00, "irq_channel_off");
        // The channel enable changes on a clock edge like every other input.
        @(posedge clk_sys);
        irq_channel_en <= 1'b1;
        sof(11'h124);
        tick(30);
        rchk(4'h5, 8'h04, 8'h04, "irq_seen");
        chk("irq_out", 8'h01, {7'h00, irq});
        wr(4'h6, 8'h04);
        tick(2);
        chk("irq_cleared", 8'h00, {7'h00, irq});
        sof(11'h125);
        tick(30);
        rchk(4'h5, 8'h04, 8'h04, "irq_again");
        wr(4'h7, 8'h00);
        tick(2);
        chk("irq_masked", 8'h00, {7'h00, irq});
        // Pin disabled: no pulse, the flag is found by polling and cleared by firmware.
        irq_channel_en <= 1'b0;
        wr(4'h0, 8'h02);
        tick(20);
        wr(4'h6, 8'h07);
        p0 = pin_low;
        sof(11'h2f0);
        tick(150);
        chk("pin_low_disabled", 8'h00, 8'(pin_low - p0));
        rchk(4'h5, 8'h01, 8'h01, "polled_start");
        rchk(4'h3, 8'hff, 8'hf0, "fnlo_polled");
        // A start left standing while the pin is off is written back as one when the pin is
        // turned on again, and that write alone must give the full pin pulse.
        p0 = pin_low;
        sof(11'h2f1);
        wr(4'h0, 8'h00);
        tick(20);
        chk("pin_low_fw_set", 8'h08, 8'(pin_low - p0));
        // Every endpoint index, then banked receive reads.
        for (int k = 0; k < 8; k++) begin
            wr(4'h1, 8'(k));
            tick(4);
            chk("ep_index", 8'(k), {5'h00, ep_index});
        end
        p0 = rd_cnt;
        wr(4'h2, 8'h02);
        tick(30);
        chk("rx_reads", 8'h02, 8'(rd_cnt - p0));
        chk("ep_reg", 8'h02, {6'h00, ep_reg});
        rchk(4'h8, 8'hff, 8'h33, "rx_data");
        rchk(4'h5, 8'h02, 8'h02, "rx_done");
        // An index change waits until the receive sequence is over.
        wr(4'h2, 8'h03);
        wr(4'h1, 8'h05);
        chk("ep_index_held", 8'h07, {5'h00, ep_index});
        tick(40);
        chk("ep_index_late", 8'h05, {5'h00, ep_index});
        // With the clock enable low a command is not even taken, so the index stays.
        ce <= 1'b0;
        wr(4'h1, 8'h02);
        tick(10);
        ce <= 1'b1;
        tick(20);
        chk("ep_index_frozen", 8'h05, {5'h00, ep_index});
        report_and_stop();
    end
endmodule

// *** verilog/fst_defs.svh ***
// Offsets, bit positions, reset values and timing counts of the frame-start tracker.
`ifndef FST_DEFS_SVH
`define FST_DEFS_SVH
// Device register offsets.
`define FST_EPSEL_OFFS 8'h0a
`define FST_BANK0_OFFS 8'h0b
`define FST_BANKN_OFFS 8'h0d
`define FST_RXPORT_OFFS 8'h0d
`define FST_FNLO_OFFS 8'h0e
`define FST_FCHI_OFFS 8'h0f
`define FST_GUARD_OFFS 8'h10
// Device reset values.
`define FST_EPSEL_RST 8'h00
`define FST_FNLO_RST 8'h00
`define FST_FCHI_RST 8'h00
// Bit positions in the frame control high register.
`define FST_B_VALID 7
`define FST_B_ANY 6
`define FST_B_IRQEN 5
`define FST_B_LOCK 4
`define FST_B_PINDIS 3
// Timing.
`define FST_PIN_TCLK 4'h8
`define FST_CLK_PERIOD_NS 10
`define FST_FRAME_PERIOD_NS 1000000
`define FST_FRAME_CYCLES (`FST_FRAME_PERIOD_NS / `FST_CLK_PERIOD_NS)
`define FST_FRAME_TOL_NS 500
`define FST_FRAME_TOL_CYCLES (`FST_FRAME_TOL_NS / `FST_CLK_PERIOD_NS)
`define FST_POLL_NS 640
`define FST_POLL_CYCLES (`FST_POLL_NS / `FST_CLK_PERIOD_NS)
// Controller command register offsets.
`define FST_H_CTRL 4'h0
`define FST_H_INDEX 4'h1
`define FST_H_RXLEN 4'h2
`define FST_H_FNLO 4'h3
`define FST_H_FNHI 4'h4
`define FST_H_STATUS 4'h5
`define FST_H_CLEAR 4'h6
`define FST_H_ENABLE 4'h7
`define FST_H_RXDATA 4'h8
`endif

// *** verilog/fst_device.sv ***
// Device end: frame-start flags, frame number capture, pin pulse and endpoint index.
`timescale 1ns/1ps
`include "fst_defs.svh"

// Summary of operation
// - Valid flag set on SOF, cleared on artificial.
// - Any-start flag set on every new frame.
// - Firmware writing one acts like hardware set.
// - Firmware clears any-start flag when pin disabled.
// - Pin enabled: flag self-clears, pin low eight.
// - Pin enabled: system detects frames by pin.
// - Interrupt needs flag, enable and channel enable.
// - Hardware never modifies the interrupt enable.
// - Read-only lock status of frame timer.
// - Pin disabled: pin held high, no pulse.
// - Frame number split high 2:0, low 7:0.
// - Frame number meaningful only while valid.
// - Artificial start leaves frame number unchanged.
// - Endpoint index selects endpoint zero to seven.
// - Index bits 7:3 read zero, written zero.
// - Banked access combines address with index.
// - No index change during receive set read.
// - Guard bit set before protected bit writes.
module fst_device
    import fst_pkg::*;
#(
    parameter int FRAME_CYCLES = `FST_FRAME_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    fst_if.dev bus,
    input wire logic sof_rx_valid,
    input wire logic [10:0] sof_rx_number,
    input wire logic irq_channel_en,
    input wire logic [23:0] ep_rdata,
    output logic [2:0] ep_index,
    output logic ep_wr,
    output logic ep_rd,
    output logic [1:0] ep_reg,
    output logic [7:0] ep_wdata
);

    fst_dev_type q;
    fst_dev_type d;

    logic art_sof;
    logic timer_locked;
    logic fw_set;
    logic fw_clr;
    logic set_evt;
    logic in_bank;
    logic [1:0] bank_k;

    // The frame timer restarts on every good token and fills in when one is missing.
    fst_frame_timer #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .sof_seen(sof_rx_valid),
        .art_sof(art_sof),
        .locked(timer_locked)
    );

    // Banked registers sit in a small window; the index picks which endpoint answers.
    assign in_bank = (bus.reg_addr >= `FST_BANK0_OFFS) && (bus.reg_addr <= `FST_BANKN_OFFS);
    assign bank_k = 2'(bus.reg_addr - `FST_BANK0_OFFS);

    // Next-state logic: register writes first, then hardware events on top.
    always_comb begin
        d = q;
        d.ep_wr = 1'b0;
        d.ep_rd = 1'b0;
        d.rdata = 8'h00;
        fw_set = 1'b0;
        fw_clr = 1'b0;

        // Register writes; unmapped offsets are ignored.
        if (bus.reg_wr) begin
            case (bus.reg_addr)
                `FST_EPSEL_OFFS: begin
                    d.ep_sel = bus.reg_wdata[2:0];
                end
                `FST_FNLO_OFFS: begin
                    d.frame_num[7:0] = bus.reg_wdata;
                end
                `FST_FCHI_OFFS: begin
                    d.frame_num[10:8] = bus.reg_wdata[2:0];
                    fw_set = bus.reg_wdata[`FST_B_ANY];
                    fw_clr = !bus.reg_wdata[`FST_B_ANY];
                    // Protected bits change only while the guard is set, so a stray
                    // write cannot flip the interrupt or pin mode.
                    if (q.guard) begin
                        d.irq_en = bus.reg_wdata[`FST_B_IRQEN];
                        d.pin_dis = bus.reg_wdata[`FST_B_PINDIS];
                    end
                end
                `FST_GUARD_OFFS: begin
                    d.guard = bus.reg_wdata[0];
                end
                default: begin
                    if (in_bank) begin
                        d.ep_wr = 1'b1;
                        d.ep_reg = bank_k;
                        d.ep_wdata = bus.reg_wdata;
                    end
                end
            endcase
        end

        // Register reads; data stand in the next cycle only.
        if (bus.reg_rd) begin
            case (bus.reg_addr)
                `FST_EPSEL_OFFS: begin
                    d.rdata = {5'h00, q.ep_sel};
                end
                `FST_FNLO_OFFS: begin
                    d.rdata = q.frame_num[7:0];
                end
                `FST_FCHI_OFFS: begin
                    d.rdata = {q.num_valid, q.any_start, q.irq_en, timer_locked,
                               q.pin_dis, q.frame_num[10:8]};
                end
                `FST_GUARD_OFFS: begin
                    d.rdata = {7'h00, q.guard};
                end
                default: begin
                    if (in_bank) begin
                        d.rdata = ep_rdata[{bank_k, 3'h0} +: 8];
                        d.ep_rd = (bus.reg_addr == `FST_RXPORT_OFFS);
                        d.ep_reg = bank_k;
                    end
                end
            endcase
        end

        // A good token beats a same-cycle firmware write of the number.
        if (sof_rx_valid) begin
            d.frame_num = sof_rx_number;
            d.num_valid = 1'b1;
        end else if (art_sof) begin
            d.num_valid = 1'b0;
        end

        // Every start sets the flag, locked or not; the set wins over any clear.
        set_evt = sof_rx_valid || art_sof || fw_set;
        if (set_evt) begin
            d.any_start = 1'b1;
        end else if (fw_clr || (!q.pin_dis && q.any_start)) begin
            d.any_start = 1'b0;
        end

        // Pin pulse: eight clocks low per start, none while the pin is disabled.
        if (d.pin_dis) begin
            d.pin_cnt = 4'h0;
        end else if (set_evt) begin
            d.pin_cnt = `FST_PIN_TCLK;
        end else if (q.pin_cnt != 4'h0) begin
            d.pin_cnt = q.pin_cnt - 4'h1;
        end
        d.pin_n = (d.pin_cnt == 4'h0);

        // Level interrupt, registered so the output has no glitch path.
        d.irq = d.any_start && d.irq_en && irq_channel_en;
    end

    // State register; the pin idles high out of reset.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
            q.pin_n <= 1'b1;
            q.ep_sel <= 3'(`FST_EPSEL_RST);
            q.frame_num <= {3'(`FST_FCHI_RST), `FST_FNLO_RST};
        end else if (ce) begin
            q <= d;
        end
    end

    // Outputs come straight from the state register.
    assign bus.reg_rdata = q.rdata;
    assign bus.frame_start_pin_n = q.pin_n;
    assign bus.dev_irq = q.irq;
    assign ep_index = q.ep_sel;
    assign ep_wr = q.ep_wr;
    assign ep_rd = q.ep_rd;
    assign ep_reg = q.ep_reg;
    assign ep_wdata = q.ep_wdata;

endmodule

// *** verilog/fst_frame_timer.sv ***
// Frame timer: tracks the frame period, makes artificial frame starts, reports lock.
`timescale 1ns/1ps
`include "fst_defs.svh"
module fst_frame_timer
    import fst_pkg::*;
#(
    parameter int FRAME_CYCLES = `FST_FRAME_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic sof_seen,
    output logic art_sof,
    output logic locked
);
    localparam int TOL = `FST_FRAME_TOL_CYCLES;
    localparam logic [16:0] LAST = 17'(FRAME_CYCLES + TOL - 1);
    localparam logic [16:0] EARLY = 17'(FRAME_CYCLES - TOL);

    fst_timer_type q;
    fst_timer_type d;

    // A received start restarts the period; lock means it came inside the window.
    always_comb begin
        d = q;
        d.art = 1'b0;
        if (sof_seen) begin
            d.locked = q.seen && (q.count >= EARLY);
            d.seen = 1'b1;
            d.count = 17'h00000;
        end else if (q.count == LAST) begin
            d.art = 1'b1;
            d.locked = 1'b0;
            d.count = 17'h00000;
        end else begin
            d.count = q.count + 17'h00001;
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign art_sof = q.art;
    assign locked = q.locked;
endmodule

// *** verilog/fst_fw_ctrl.sv ***
// Controller end: drives the device register port on behalf of a command port.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "fst_defs.svh"
module fst_fw_ctrl
    import fst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    fst_if.fw bus,
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata,
    output logic irq
);
    fst_host_type q;
    fst_host_type d;
    logic [2:0] st_set;
    logic [2:0] st_clr;

    // One device access at a time; reads are taken two cycles after issue.
    always_comb begin
        d = q;
        d.reg_wr = 1'b0;
        d.reg_rd = 1'b0;
        d.cmd_rdata = 8'h00;
        st_set = {bus.dev_irq, 2'b00};
        st_clr = 3'b000;
        d.pin_prev = bus.frame_start_pin_n;
        d.poll = (q.poll == 6'(`FST_POLL_CYCLES - 1)) ? 6'h00 : q.poll + 6'h01;
        unique case (q.state)
            H_IDLE: begin
                if (q.frame_pending_write_guard) begin
                    d.frame_pending_write_guard = 1'b0;
                    d.reg_rd = 1'b1;
                    d.reg_addr = `FST_FCHI_OFFS;
                    d.kind = K_HIGH;
                    d.state = H_WAIT;
                end else if (q.apply_pending_write_guard) begin
                    d.reg_rd = 1'b1;
                    d.reg_addr = `FST_FCHI_OFFS;
                    d.kind = K_APPLY;
                    d.state = H_WAIT;
                end else if (q.index_pending_write_guard && q.rx_left == 8'h00) begin
                    d.index_pending_write_guard = 1'b0;
                    d.reg_wr = 1'b1;
                    d.reg_addr = `FST_EPSEL_OFFS;
                    d.reg_wdata = {5'h00, q.want_index};
                end else if (q.rx_left != 8'h00) begin
                    d.reg_rd = 1'b1;
                    d.reg_addr = `FST_RXPORT_OFFS;
                    d.kind = K_FIFO;
                    d.state = H_WAIT;
                end
            end
            H_WAIT: d.state = H_TAKE;
            H_TAKE: begin
                d.state = H_IDLE;
                unique case (q.kind)
                    K_HIGH: begin
                        d.hi_copy = bus.reg_rdata;
                        // Polling only counts when the flag was actually up.
                        if (!q.cur_pin_dis || bus.reg_rdata[`FST_B_ANY]) begin
                            d.fn_valid = bus.reg_rdata[`FST_B_VALID];
                            d.locked = bus.reg_rdata[`FST_B_LOCK];
                            d.fn[10:8] = bus.reg_rdata[2:0];
                            st_set[0] = 1'b1;
                            d.state = q.cur_pin_dis ? H_CLR_FLAG : H_RD_LOW;
                        end
                    end
                    K_LOW: d.fn[7:0] = bus.reg_rdata;
                    K_FIFO: begin
                        d.rx_data = bus.reg_rdata;
                        d.rx_left = q.rx_left - 8'h01;
                        st_set[1] = (q.rx_left == 8'h01);
                    end
                    K_APPLY: begin
                        d.hi_copy = bus.reg_rdata;
                        d.state = H_GUARD_ON;
                    end
                endcase
            end
            H_GUARD_ON: begin
                d.reg_wr = 1'b1;
                d.reg_addr = `FST_GUARD_OFFS;
                d.reg_wdata = 8'h01;
                d.state = H_WR_CTRL;
            end
            H_WR_CTRL: begin
                // Written back from the copy just read; a token landing in between
                // can lose its high number bits, a known limitation.
                d.reg_wr = 1'b1;
                d.reg_addr = `FST_FCHI_OFFS;
                d.reg_wdata = {1'b0, q.hi_copy[`FST_B_ANY], q.want_irq_en, 1'b0,
                               q.want_pin_dis, q.hi_copy[2:0]};
                d.cur_pin_dis = q.want_pin_dis;
                d.apply_pending_write_guard = 1'b0;
                d.state = H_GUARD_OFF;
            end
            H_GUARD_OFF: begin
                d.reg_wr = 1'b1;
                d.reg_addr = `FST_GUARD_OFFS;
                d.reg_wdata = 8'h00;
                d.state = H_IDLE;
            end
            H_CLR_FLAG: begin
                d.reg_wr = 1'b1;
                d.reg_addr = `FST_FCHI_OFFS;
                d.reg_wdata = {5'h00, q.hi_copy[2:0]};
                d.state = H_RD_LOW;
            end
            H_RD_LOW: begin
                d.reg_rd = 1'b1;
                d.reg_addr = `FST_FNLO_OFFS;
                d.kind = K_LOW;
                d.state = H_WAIT;
            end
        endcase

        // Frame starts come from the pin edge, or from polling when the pin is off.
        if (q.cur_pin_dis ? (q.poll == 6'h00) : (q.pin_prev && !bus.frame_start_pin_n)) begin
            d.frame_pending_write_guard = 1'b1;
        end

        // Command port writes; they land after the state machine so sets win.
        if (cmd_wr) begin
            case (cmd_addr)
                `FST_H_CTRL: begin
                    d.want_irq_en = cmd_wdata[0];
                    d.want_pin_dis = cmd_wdata[1];
                    d.apply_pending_write_guard = 1'b1;
                end
                `FST_H_INDEX: begin
                    d.want_index = cmd_wdata[2:0];
                    d.index_pending_write_guard = 1'b1;
                end
                `FST_H_RXLEN: d.rx_left = cmd_wdata;
                `FST_H_CLEAR: st_clr = cmd_wdata[2:0];
                `FST_H_ENABLE: d.enable = cmd_wdata[2:0];
                default: ;
            endcase
        end
        d.status = (q.status & ~st_clr) | st_set;

        // Command port reads.
        if (cmd_rd) begin
            case (cmd_addr)
                `FST_H_CTRL: d.cmd_rdata = {6'h00, q.want_pin_dis, q.want_irq_en};
                `FST_H_INDEX: d.cmd_rdata = {5'h00, q.want_index};
                `FST_H_RXLEN: d.cmd_rdata = q.rx_left;
                `FST_H_FNLO: d.cmd_rdata = q.fn[7:0];
                `FST_H_FNHI: d.cmd_rdata = {q.fn_valid, 2'b00, q.locked, 1'b0, q.fn[10:8]};
                `FST_H_STATUS: d.cmd_rdata = {5'h00, q.status};
                `FST_H_ENABLE: d.cmd_rdata = {5'h00, q.enable};
                `FST_H_RXDATA: d.cmd_rdata = q.rx_data;
                default: d.cmd_rdata = 8'h00;
            endcase
        end
        d.irq = |(d.status & d.enable);
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
            q.state <= H_IDLE;
            q.kind <= K_HIGH;
            q.pin_prev <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign bus.reg_addr = q.reg_addr;
    assign bus.reg_wdata = q.reg_wdata;
    assign bus.reg_wr = q.reg_wr;
    assign bus.reg_rd = q.reg_rd;
    assign cmd_rdata = q.cmd_rdata;
    assign irq = q.irq;
endmodule

// *** verilog/fst_if.sv ***
// Register port and frame-start pin between the device and its controller.
`timescale 1ns/1ps
interface fst_if;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic frame_start_pin_n;
    logic dev_irq;

    modport dev (
        input reg_addr,
        input reg_wdata,
        input reg_wr,
        input reg_rd,
        output reg_rdata,
        output frame_start_pin_n,
        output dev_irq
    );

    modport fw (
        output reg_addr,
        output reg_wdata,
        output reg_wr,
        output reg_rd,
        input reg_rdata,
        input frame_start_pin_n,
        input dev_irq
    );
endinterface

// *** verilog/fst_pkg.sv ***
// Types shared by the frame-start tracker device end and its controller.
package fst_pkg;

    typedef struct packed {
        logic [16:0] count;
        logic art;
        logic locked;
        logic seen;
    } fst_timer_type;

    typedef struct packed {
        logic [2:0] ep_sel;
        logic [10:0] frame_num;
        logic num_valid;
        logic any_start;
        logic irq_en;
        logic pin_dis;
        logic guard;
        logic [3:0] pin_cnt;
        logic pin_n;
        logic irq;
        logic [7:0] rdata;
        logic ep_wr;
        logic ep_rd;
        logic [1:0] ep_reg;
        logic [7:0] ep_wdata;
    } fst_dev_type;

    typedef enum logic [3:0] {
        H_IDLE, H_WAIT, H_TAKE, H_GUARD_ON, H_WR_CTRL, H_GUARD_OFF, H_CLR_FLAG, H_RD_LOW
    } fst_hstate_type;

    typedef enum logic [1:0] {K_HIGH, K_LOW, K_FIFO, K_APPLY} fst_kind_type;

    typedef struct packed {
        fst_hstate_type state;
        fst_kind_type kind;
        logic [7:0] reg_addr;
        logic [7:0] reg_wdata;
        logic reg_wr;
        logic reg_rd;
        logic want_irq_en;
        logic want_pin_dis;
        logic cur_pin_dis;
        logic apply_pending_write_guard;
        logic [2:0] want_index;
        logic index_pending_write_guard;
        logic [7:0] rx_left;
        logic [7:0] rx_data;
        logic [7:0] hi_copy;
        logic [10:0] fn;
        logic fn_valid;
        logic locked;
        logic [2:0] status;
        logic [2:0] enable;
        logic pin_prev;
        logic frame_pending_write_guard;
        logic [5:0] poll;
        logic [7:0] cmd_rdata;
        logic irq;
    } fst_host_type;

endpackage
